// ==== hss_top.sv ====
// Overview of operation
// (R1) hall level bit is read-only: 1 high/low current, 0 low/high current
// (R2) hall over-current flag reads 1 once an over-current occurred
// (R3) switched supply active only with stage enable, then follows its on bit
// (R4) low and high voltage flags never affect switched supply enable
// (R5) supply over-current limits output current and sets its status flag
// (R6) output control offset 02 holds supply on bit, cleared by reset
// (R7) per-switch force-on bit, read/write, 1 turns switch on, reset clears
// (R8) per-switch pwm select bit makes switch follow pwm input
// (R9) per-switch over-current flag, write 1 clears and re-enables driver
// (R10) supply over-current flag at offset 04, write 1 clears, re-enables
// (R11) glass driven by switch plus level set by 6-bit dac code
// (R12) open-load test bit measures glass pin, flag set above threshold
// (R13) glass drive held off while open-load test bit is set
// (R14) glass short sets glass over-current flag and disables glass drive
// (R15) switch on by force or pwm, forced off while its flag is set
module hss_top
  import hss_pkg::*;
(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // serial register port
  input  wire logic        spi_sclk,
  input  wire logic        spi_cs_n,
  input  wire logic        spi_mosi,
  output logic             spi_miso,
  output logic             spi_miso_oe_n,
  // analog sense inputs
  input  wire hss_sense_t  sense,
  // power stage drive
  output hss_drive_t       drive
);

  // ------------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------------
  localparam int IN_W = 3 + $bits(hss_sense_t);
  // idle pattern: sclk low, cs_n high, so no false frame after reset
  localparam logic [IN_W-1:0] SYNC_IDLE =
    {3'h2, {$bits(hss_sense_t){1'b0}}};

  logic [IN_W-1:0] sync1_reg;
  logic [IN_W-1:0] sync2_reg;
  logic            sclk_d_reg;
  hss_sense_t      sense_s;
  logic            sclk_s;
  logic            cs_n_s;
  logic            mosi_s;

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      sync1_reg  <= SYNC_IDLE;
      sync2_reg  <= SYNC_IDLE;
      sclk_d_reg <= 1'b0;
    end
    else
    begin
      sync1_reg  <= {spi_sclk, spi_cs_n, spi_mosi, sense};
      sync2_reg  <= sync1_reg;
      sclk_d_reg <= sclk_s;
    end
  end

  assign {sclk_s, cs_n_s, mosi_s, sense_s} = sync2_reg;

  // ------------------------------------------------------------------
  // sticky flags
  // ------------------------------------------------------------------
  logic [NUM_FLAGS-1:0] flag_set;
  logic [NUM_FLAGS-1:0] flag_clr;
  logic [NUM_FLAGS-1:0] flags;
  logic [7:0]           glass_ctrl_reg;

  // event sources for each flag
  always_comb
  begin
    flag_set = '0;
    flag_set[FLG_HS0 +: NUM_HS] = sense_s.hs_overcurrent;          // R9
    flag_set[FLG_SUPPLY]   = sense_s.supply_overcurrent;          // R5
    flag_set[FLG_HALL]     = sense_s.hall_overcurrent;            // R2
    flag_set[FLG_GLASS_OL] = glass_ctrl_reg[GLC_TEST]
                             & sense_s.glass_openload;            // R12
    flag_set[FLG_GLASS_OC] = sense_s.glass_short;                 // R14
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_FLAGS; gi++)
    begin : g_flag
      hss_sticky_flag u_flag
      (
        .clock (clock),
        .rst   (rst),
        .set   (flag_set[gi]),
        .clear (flag_clr[gi]),
        .flag  (flags[gi])
      );
    end
  endgenerate

  // ------------------------------------------------------------------
  // register read mux
  // ------------------------------------------------------------------
  logic [7:0] sys_ctrl_reg;
  logic [7:0] hs_out_reg;
  logic [7:0] glass_level_reg;

  function automatic logic [7:0] read_reg(input logic [5:0] a);
    logic [7:0] d;
    d = 8'h00;
    if (a == ADDR_SYS_CTRL)
      d = sys_ctrl_reg;
    else if (a == ADDR_HS_OUT)
      d = hs_out_reg;
    else if (a == ADDR_HS_STAT)
    begin
      d[HST_OCF_LSB +: NUM_HS] = flags[FLG_HS0 +: NUM_HS];
      d[HST_SUPPLY_OCF]        = flags[FLG_SUPPLY];
    end
    else if (a == ADDR_GLASS_LEVEL)
      d = glass_level_reg;
    else if (a == ADDR_GLASS_CTRL)
    begin
      d[GLC_TEST] = glass_ctrl_reg[GLC_TEST];
      d[GLC_OLF]  = flags[FLG_GLASS_OL];
      d[GLC_OCF]  = flags[FLG_GLASS_OC];
    end
    else if (a == ADDR_HALL)
    begin
      d[HALL_LEVEL] = sense_s.hall_level;                         // R1
      d[HALL_OCF]   = flags[FLG_HALL];                            // R2
    end
    return d;
  endfunction : read_reg

  // ------------------------------------------------------------------
  // serial frame engine: address byte then data byte, msb first
  // ------------------------------------------------------------------
  hss_spi_state_t state_reg;
  hss_spi_state_t state_next;
  logic [3:0]     cnt_reg;
  logic [3:0]     cnt_next;
  logic [7:0]     rx_reg;
  logic [7:0]     rx_next;
  logic [7:0]     tx_reg;
  logic [7:0]     tx_next;
  logic [7:0]     addr_reg;
  logic [7:0]     addr_next;
  logic           miso_reg;
  logic           miso_next;
  logic           oe_n_reg;
  logic           oe_n_next;
  logic           wr_stb_reg;
  logic           wr_stb_next;
  logic [7:0]     wr_data_reg;
  logic [7:0]     wr_data_next;
  logic           sclk_rise;
  logic           sclk_fall;
  logic [7:0]     rx_shift;

  assign sclk_rise = sclk_s & ~sclk_d_reg;
  assign sclk_fall = ~sclk_s & sclk_d_reg;
  assign rx_shift  = {rx_reg[6:0], mosi_s};

  // frame sequencing and shift registers
  always_comb
  begin
    state_next   = state_reg;
    cnt_next     = cnt_reg;
    rx_next      = rx_reg;
    tx_next      = tx_reg;
    addr_next    = addr_reg;
    miso_next    = miso_reg;
    oe_n_next    = cs_n_s;
    wr_stb_next  = 1'b0;
    wr_data_next = wr_data_reg;
    case (state_reg)
      SPI_IDLE:
      begin
        cnt_next = 4'h0;
        if (!cs_n_s)
          state_next = SPI_ADDR;
      end
      SPI_ADDR, SPI_DATA:
      begin
        if (cs_n_s)
          state_next = SPI_IDLE;
        else if (sclk_rise)
        begin
          rx_next  = rx_shift;
          cnt_next = cnt_reg + 4'h1;
          if (cnt_reg == ADDR_LAST_BIT)
          begin
            addr_next  = rx_shift;
            tx_next    = read_reg(rx_shift[5:0]);
            state_next = SPI_DATA;
          end
          else if (cnt_reg == DATA_LAST_BIT)
          begin
            wr_stb_next  = addr_reg[SPI_WRITE_BIT];
            wr_data_next = rx_shift;
            state_next   = SPI_DONE;
          end
        end
        else if (sclk_fall && state_reg == SPI_DATA)
        begin
          miso_next = tx_reg[7];
          tx_next   = {tx_reg[6:0], 1'b0};
        end
      end
      default:
      begin
        if (cs_n_s)
          state_next = SPI_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      state_reg   <= SPI_IDLE;
      cnt_reg     <= 4'h0;
      rx_reg      <= 8'h00;
      tx_reg      <= 8'h00;
      addr_reg    <= 8'h00;
      miso_reg    <= 1'b0;
      oe_n_reg    <= 1'b1;
      wr_stb_reg  <= 1'b0;
      wr_data_reg <= 8'h00;
    end
    else
    begin
      state_reg   <= state_next;
      cnt_reg     <= cnt_next;
      rx_reg      <= rx_next;
      tx_reg      <= tx_next;
      addr_reg    <= addr_next;
      miso_reg    <= miso_next;
      oe_n_reg    <= oe_n_next;
      wr_stb_reg  <= wr_stb_next;
      wr_data_reg <= wr_data_next;
    end
  end

  // ------------------------------------------------------------------
  // control registers and write-one-to-clear decode
  // ------------------------------------------------------------------
  logic [7:0] sys_ctrl_next;
  logic [7:0] hs_out_next;
  logic [7:0] glass_level_next;
  logic [7:0] glass_ctrl_next;
  logic [5:0] wa;

  assign wa = addr_reg[5:0];

  always_comb
  begin
    sys_ctrl_next    = sys_ctrl_reg;
    hs_out_next      = hs_out_reg;
    glass_level_next = glass_level_reg;
    glass_ctrl_next  = glass_ctrl_reg;
    flag_clr         = '0;
    if (wr_stb_reg)
    begin
      if (wa == ADDR_SYS_CTRL)
      begin
        sys_ctrl_next          = REG_RESET;
        sys_ctrl_next[SYS_PSE] = wr_data_reg[SYS_PSE];
      end
      else if (wa == ADDR_HS_OUT)
        hs_out_next = wr_data_reg & 8'hBF;                 // R6 R7 R8
      else if (wa == ADDR_HS_STAT)
      begin
        flag_clr[FLG_HS0 +: NUM_HS] =
          wr_data_reg[HST_OCF_LSB +: NUM_HS];              // R9
        flag_clr[FLG_SUPPLY] = wr_data_reg[HST_SUPPLY_OCF]; // R10
      end
      else if (wa == ADDR_GLASS_LEVEL)
        glass_level_next = wr_data_reg & 8'hBF;            // R11
      else if (wa == ADDR_GLASS_CTRL)
      begin
        glass_ctrl_next           = REG_RESET;
        glass_ctrl_next[GLC_TEST] = wr_data_reg[GLC_TEST]; // R12
        flag_clr[FLG_GLASS_OL] = wr_data_reg[GLC_OLF];
        flag_clr[FLG_GLASS_OC] = wr_data_reg[GLC_OCF];
      end
      else if (wa == ADDR_HALL)
        flag_clr[FLG_HALL] = wr_data_reg[HALL_OCF];
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      sys_ctrl_reg    <= REG_RESET;
      hs_out_reg      <= REG_RESET;                        // R6 R7 R8
      glass_level_reg <= REG_RESET;
      glass_ctrl_reg  <= REG_RESET;
    end
    else
    begin
      sys_ctrl_reg    <= sys_ctrl_next;
      hs_out_reg      <= hs_out_next;
      glass_level_reg <= glass_level_next;
      glass_ctrl_reg  <= glass_ctrl_next;
    end
  end

  // ------------------------------------------------------------------
  // power stage drive
  // ------------------------------------------------------------------
  hss_drive_t drive_reg;
  hss_drive_t drive_next;

  always_comb
  begin
    drive_next.hs_drive = (hs_out_reg[HSO_FORCE_LSB +: NUM_HS]
      | (hs_out_reg[HSO_PWM_LSB +: NUM_HS] & {NUM_HS{sense_s.pwm}}))
      & ~flags[FLG_HS0 +: NUM_HS];                         // R15 R7 R8 R9
    // voltage flags take no part here
    drive_next.supply_enable = sys_ctrl_reg[SYS_PSE]
      & hs_out_reg[HSO_SUPPLY_ON] & ~flags[FLG_SUPPLY];    // R3 R4 R10
    drive_next.supply_limit = sense_s.supply_overcurrent;  // R5
    drive_next.glass_switch = glass_level_reg[GLV_ENABLE]
      & ~glass_ctrl_reg[GLC_TEST]
      & ~flags[FLG_GLASS_OC];                              // R11 R13 R14
    drive_next.glass_level = glass_level_reg[DAC_W-1:0];   // R11
    drive_next.glass_test_source = glass_ctrl_reg[GLC_TEST]; // R12
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      drive_reg <= '0;
    else
      drive_reg <= drive_next;
  end

  assign drive         = drive_reg;
  assign spi_miso      = miso_reg;
  assign spi_miso_oe_n = oe_n_reg;

endmodule : hss_top

// ==== hss_pkg.sv ====
package hss_pkg;

  // ------------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------------
  localparam logic [5:0] ADDR_SYS_CTRL    = 6'h01;
  localparam logic [5:0] ADDR_HS_OUT      = 6'h02;
  localparam logic [5:0] ADDR_HS_STAT     = 6'h04;
  localparam logic [5:0] ADDR_GLASS_LEVEL = 6'h05;
  localparam logic [5:0] ADDR_GLASS_CTRL  = 6'h06;
  localparam logic [5:0] ADDR_HALL        = 6'h07;

  // ------------------------------------------------------------------
  // field positions and widths
  // ------------------------------------------------------------------
  localparam int NUM_HS         = 3;
  localparam int DAC_W          = 6;
  localparam int SYS_PSE        = 0;
  localparam int HSO_FORCE_LSB  = 0;
  localparam int HSO_PWM_LSB    = 3;
  localparam int HSO_SUPPLY_ON  = 7;
  localparam int HST_OCF_LSB    = 0;
  localparam int HST_SUPPLY_OCF = 7;
  localparam int GLV_ENABLE     = 7;
  localparam int GLC_TEST       = 0;
  localparam int GLC_OLF        = 1;
  localparam int GLC_OCF        = 2;
  localparam int HALL_LEVEL     = 0;
  localparam int HALL_OCF       = 1;

  // sticky flag indices
  localparam int FLG_HS0      = 0;
  localparam int FLG_SUPPLY   = 3;
  localparam int FLG_HALL     = 4;
  localparam int FLG_GLASS_OL = 5;
  localparam int FLG_GLASS_OC = 6;
  localparam int NUM_FLAGS    = 7;

  // ------------------------------------------------------------------
  // serial frame and reset values
  // ------------------------------------------------------------------
  localparam int         SPI_WRITE_BIT = 7;
  localparam logic [3:0] ADDR_LAST_BIT = 4'h7;
  localparam logic [3:0] DATA_LAST_BIT = 4'hF;
  localparam logic [7:0] REG_RESET     = 8'h00;

  typedef enum logic [1:0]
  {
    SPI_IDLE = 2'b00,
    SPI_ADDR = 2'b01,
    SPI_DATA = 2'b10,
    SPI_DONE = 2'b11
  } hss_spi_state_t;

  // analog comparator and pin inputs, all asynchronous
  typedef struct packed
  {
    logic [NUM_HS-1:0] hs_overcurrent;
    logic              supply_overcurrent;
    logic              hall_level;
    logic              hall_overcurrent;
    logic              glass_openload;
    logic              glass_short;
    logic              pwm;
  } hss_sense_t;

  // drive outputs to the power stages
  typedef struct packed
  {
    logic [NUM_HS-1:0] hs_drive;
    logic              supply_enable;
    logic              supply_limit;
    logic              glass_switch;
    logic [DAC_W-1:0]  glass_level;
    logic              glass_test_source;
  } hss_drive_t;

endpackage : hss_pkg

// ==== hss_sticky_flag.sv ====
// one event flag: hardware sets, software clears, set wins
module hss_sticky_flag
  import hss_pkg::*;
(
  // clock and reset
  input  wire logic clock,
  input  wire logic rst,
  // set and clear
  input  wire logic set,
  input  wire logic clear,
  // state
  output logic      flag
);

  logic flag_reg;
  logic flag_next;

  // set takes priority over a same-cycle clear
  always_comb
  begin
    flag_next = flag_reg;
    if (set)
      flag_next = 1'b1;
    else if (clear)
      flag_next = 1'b0;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      flag_reg <= 1'b0;
    else
      flag_reg <= flag_next;
  end

  assign flag = flag_reg;

endmodule : hss_sticky_flag

// ==== hss_load_model.sv ====
// loads and pins around the block, faults on bench command
module hss_load_model
  import hss_pkg::*;
(
  // drive from the block
  input  wire hss_drive_t        drive,
  // fault and pin commands from the bench
  input  wire logic [NUM_HS-1:0] hs_short,
  input  wire logic              supply_short,
  input  wire logic              glass_short,
  input  wire logic              glass_open,
  input  wire logic              hall_high,
  input  wire logic              hall_short,
  input  wire logic              pwm_in,
  // comparator outputs
  output hss_sense_t             sense
);
  timeunit 1ns;
  timeprecision 1ps;

  // a shorted load trips its comparator whatever the drive
  always_comb
  begin
    sense.hs_overcurrent     = hs_short;
    sense.supply_overcurrent = supply_short;
    sense.hall_level         = hall_high;
    sense.hall_overcurrent   = hall_short;
    sense.glass_short        = glass_short;
    sense.pwm                = pwm_in;
    // open pin rises only with the test current flowing
    sense.glass_openload     = glass_open & drive.glass_test_source;
  end
endmodule : hss_load_model

// ==== hss_top_asserts.sv ====
// port checker for the high side block
module hss_top_asserts
  import hss_pkg::*;
(
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rst,
  // serial port
  input  wire logic       spi_sclk,
  input  wire logic       spi_cs_n,
  input  wire logic       spi_mosi,
  input  wire logic       spi_miso,
  input  wire logic       spi_miso_oe_n,
  // pins
  input  wire hss_sense_t sense,
  input  wire hss_drive_t drive
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  // fault held long enough to pass sync, flag and drive stages
  sequence s_held5(logic s);
    s [*5];
  endsequence

  a_hs0_oc_off: assert property (s_held5(sense.hs_overcurrent[0])
    |-> !drive.hs_drive[0]) else $error("switch 0 on in over-current");
  a_hs2_oc_off: assert property (s_held5(sense.hs_overcurrent[2])
    |-> !drive.hs_drive[2]) else $error("switch 2 on in over-current");
  a_supply_oc_off: assert property (s_held5(sense.supply_overcurrent)
    |-> !drive.supply_enable) else $error("supply on in over-current");
  a_supply_limit: assert property (sense.supply_overcurrent [*4]
    |-> drive.supply_limit) else $error("supply not limited");
  a_glass_short_off: assert property (s_held5(sense.glass_short)
    |-> !drive.glass_switch) else $error("glass on while shorted");
  a_test_glass_off: assert property (drive.glass_test_source
    |-> !drive.glass_switch) else $error("glass on during load test");
  a_reset_clear: assert property ($fell(rst)
    |-> drive == '0) else $error("drive not cleared by reset");
  a_idle_oe: assert property (spi_cs_n [*4]
    |-> spi_miso_oe_n) else $error("data out driven while deselected");
  a_sel_oe: assert property (!spi_cs_n [*4]
    |-> !spi_miso_oe_n) else $error("data out not driven while selected");
endmodule : hss_top_asserts

bind hss_top hss_top_asserts u_hss_top_asserts (.clock, .rst, .spi_sclk,
  .spi_cs_n, .spi_mosi, .spi_miso, .spi_miso_oe_n, .sense, .drive);

// ==== tb_hss_top.sv ====
module tb_hss_top
  import hss_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic              clock, rst, sclk, cs_n, mosi, miso, oe_n;
  hss_sense_t        sense;
  hss_drive_t        drive;
  logic [NUM_HS-1:0] hs_short;
  logic              supply_short, glass_short, glass_open;
  logic              hall_high, hall_short, pwm_in;
  int                fails, num_checks, cycles;

  hss_top u_hss_top (.clock(clock), .rst(rst), .spi_sclk(sclk),
    .spi_cs_n(cs_n), .spi_mosi(mosi), .spi_miso(miso),
    .spi_miso_oe_n(oe_n), .sense(sense), .drive(drive));

  hss_load_model u_hss_load_model (.drive(drive), .hs_short(hs_short),
    .supply_short(supply_short), .glass_short(glass_short),
    .glass_open(glass_open), .hall_high(hall_high),
    .hall_short(hall_short), .pwm_in(pwm_in), .sense(sense));

  // clock and hang guard
  always #10 clock = ~clock;
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fails++;
      report_and_stop();
    end
  end

  // --------------------------------------------------------------
  // tasks
  // --------------------------------------------------------------
  task tick(input int n);
    repeat (n) @(posedge clock);
  endtask : tick

  task chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one 16 bit frame, four cycles per sclk phase, msb first
  task xfer(input logic [15:0] frame, output logic [7:0] q);
    cs_n <= 1'b0;
    for (int i = 15; i >= 0; i--)
    begin
      mosi <= frame[i];
      tick(4);
      if (i < 8)
        q[i] = miso;
      sclk <= 1'b1;
      tick(4);
      sclk <= 1'b0;
    end
    tick(4);
    cs_n <= 1'b1;
    tick(6);
  endtask : xfer

  task wr(input logic [5:0] a, input logic [7:0] d);
    logic [7:0] q;
    xfer({2'b10, a, d}, q);
  endtask : wr

  task rd_chk(input logic [5:0] a, input logic [7:0] exp);
    logic [7:0] q;
    xfer({2'b00, a, 8'h00}, q);
    chk(q, exp);
  endtask : rd_chk

  task report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : report_and_stop

  // --------------------------------------------------------------
  // tests
  // --------------------------------------------------------------
  initial
  begin
    {clock, sclk, mosi, hs_short, supply_short, glass_short} = '0;
    {glass_open, hall_high, hall_short, pwm_in} = '0;
    rst = 1'b1;
    cs_n = 1'b1;
    tick(20);
    rst <= 1'b0;
    tick(2);
    rd_chk(ADDR_HS_OUT, 8'h00);
    rd_chk(ADDR_HS_STAT, 8'h00);
    wr(ADDR_HS_OUT, 8'h80);
    chk({7'h00, drive.supply_enable}, 8'h00);
    wr(ADDR_SYS_CTRL, 8'h01);
    chk({7'h00, drive.supply_enable}, 8'h01);
    rd_chk(ADDR_HS_OUT, 8'h80);
    for (int i = 0; i < NUM_HS; i++)
    begin
      wr(ADDR_HS_OUT, 8'h80 | (8'h01 << i));
      chk({5'h00, drive.hs_drive}, 8'h01 << i);
    end
    wr(ADDR_HS_OUT, 8'hB8);
    pwm_in <= 1'b1;
    tick(4);
    chk({5'h00, drive.hs_drive}, 8'h07);
    pwm_in <= 1'b0;
    tick(4);
    chk({5'h00, drive.hs_drive}, 8'h00);
    // switch fault, write 0 ignored, write 1 clears
    wr(ADDR_HS_OUT, 8'h87);
    hs_short <= 3'h5;
    tick(6);
    chk({5'h00, drive.hs_drive}, 8'h02);
    hs_short <= 3'h0;
    wr(ADDR_HS_STAT, 8'h00);
    rd_chk(ADDR_HS_STAT, 8'h05);
    wr(ADDR_HS_STAT, 8'h01);
    rd_chk(ADDR_HS_STAT, 8'h04);
    wr(ADDR_HS_STAT, 8'h04);
    rd_chk(ADDR_HS_STAT, 8'h00);
    chk({5'h00, drive.hs_drive}, 8'h07);
    // supply fault
    supply_short <= 1'b1;
    tick(6);
    chk({6'h00, drive.supply_limit, drive.supply_enable}, 8'h02);
    supply_short <= 1'b0;
    rd_chk(ADDR_HS_STAT, 8'h80);
    wr(ADDR_HS_STAT, 8'h80);
    chk({6'h00, drive.supply_limit, drive.supply_enable}, 8'h01);
    // glass level, load test and short
    wr(ADDR_GLASS_LEVEL, 8'hA5);
    chk({1'b0, drive.glass_switch, drive.glass_level}, 8'h65);
    wr(ADDR_GLASS_CTRL, 8'h01);
    glass_open <= 1'b1;
    tick(6);
    chk({6'h00, drive.glass_test_source, drive.glass_switch}, 8'h02);
    rd_chk(ADDR_GLASS_CTRL, 8'h03);
    glass_open <= 1'b0;
    wr(ADDR_GLASS_CTRL, 8'h02);
    rd_chk(ADDR_GLASS_CTRL, 8'h00);
    chk({7'h00, drive.glass_switch}, 8'h01);
    glass_short <= 1'b1;
    tick(6);
    chk({7'h00, drive.glass_switch}, 8'h00);
    glass_short <= 1'b0;
    rd_chk(ADDR_GLASS_CTRL, 8'h04);
    // hall level and over-current
    hall_high <= 1'b1;
    tick(4);
    rd_chk(ADDR_HALL, 8'h01);
    hall_high <= 1'b0;
    hall_short <= 1'b1;
    tick(6);
    hall_short <= 1'b0;
    rd_chk(ADDR_HALL, 8'h02);
    wr(ADDR_HALL, 8'h03);
    rd_chk(ADDR_HALL, 8'h00);
    // unmapped place, then a second reset
    wr(6'h03, 8'hFF);
    rd_chk(6'h03, 8'h00);
    rst <= 1'b1;
    tick(20);
    rst <= 1'b0;
    tick(2);
    rd_chk(ADDR_HS_OUT, 8'h00);
    report_and_stop();
  end
endmodule : tb_hss_top
